/* rtl/clock_ctrl_pkg.sv */
// Shared constants, register map and types of the power-save and clock control block.
package clock_ctrl_pkg;

  // Register bus geometry.
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 4;

  // Register word offsets.
  localparam logic [ADDR_W-1:0] ADDR_DIVREG = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_FBDIV  = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_MODDIS = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h3;

  // Clock divisor register: bit 15 return on interrupt, 14:12 ratio, 11 slow CPU enable.
  localparam int unsigned RATIO_W  = 3;
  localparam int unsigned DIVCNT_W = 7;
  localparam int unsigned DIVREG_RSVD_W = 11;

  typedef struct packed {
    logic                     return_on_interrupt_bit;
    logic [RATIO_W-1:0]       ratio;
    logic                     slow_cpu_enable_bit;
    logic [DIVREG_RSVD_W-1:0] rsvd;
  } divreg_t;

  localparam divreg_t DIVREG_RST = 16'h0000;

  // PLL feedback divisor: 9-bit field, multiplier is field plus two.
  localparam int unsigned     FBDIV_W      = 9;
  localparam int unsigned     MULT_W       = 10;
  localparam logic [8:0]      FBDIV_RST    = 9'h030;
  localparam logic [9:0]      PLL_MULT_OFS = 10'h002;

  // Peripheral module disable bits.
  localparam int unsigned NUM_PERIPH = 8;
  localparam logic [7:0]  MODDIS_RST = 8'h00;

  // Status register bit positions.
  localparam int unsigned ST_BIT_IDLE  = 0;
  localparam int unsigned ST_BIT_SLEEP = 1;
  localparam int unsigned ST_BIT_DOZE  = 2;
  localparam int unsigned ST_BIT_WAKE  = 3;
  localparam int unsigned ST_BIT_BYIRQ = 4;
  localparam int unsigned ST_BIT_BYWDT = 5;

  // Cycles held in the wake state before the CPU clock returns (resume lands within 2 to 4).
  localparam int unsigned WAKE_CNT_W = 2;
  localparam logic [1:0]  WAKE_LAST  = 2'h1;

  // Power-save instruction request from the CPU core.
  typedef struct packed {
    logic valid;
    logic sleep;
  } psave_req_t;

  typedef enum {
    ST_RUN,
    ST_ENTER,
    ST_IDLE,
    ST_SLEEP,
    ST_WAKE
  } pwr_state_t;

endpackage

/* rtl/doze_divider.sv */
// CPU clock enable divider for the slow-CPU mode.
`timescale 1ns/1ps

module doze_divider (
  // Clock and reset
  input  wire logic                                clk_i,
  input  wire logic                                rst_i,
  // Control
  input  wire logic                                run_i,
  input  wire logic                                doze_i,
  input  wire logic [clock_ctrl_pkg::RATIO_W-1:0]  ratio_i,
  // CPU tick
  output logic                                     tick_o
);

  logic [clock_ctrl_pkg::DIVCNT_W-1:0] cnt_r;
  logic [clock_ctrl_pkg::DIVCNT_W-1:0] cnt_nxt;
  logic [clock_ctrl_pkg::DIVCNT_W-1:0] mask;

  // Code n keeps the low n counter bits, so the period is two to the power n.
  genvar b;
  generate
    for (b = 0; b < clock_ctrl_pkg::DIVCNT_W; b++) begin : g_mask
      assign mask[b] = (32'(ratio_i) > b);
    end
  endgenerate

  assign cnt_nxt = (cnt_r + 7'h01) & mask;

  // The counter restarts at zero so the first CPU tick after a stop comes at once.
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i || !doze_i) begin
      cnt_r <= 7'h00;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // The CPU tick comes from one counter on the system clock, so it never slips against the peripheral clock.
  assign tick_o = !doze_i || ((cnt_r & mask) == 7'h00);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ratio_two_a: assert property (run_i && doze_i && ratio_i == 3'h1 && $stable(ratio_i)
      && tick_o |=> !tick_o ##1 (tick_o || !doze_i || ratio_i != 3'h1))
    else $error("Ratio code one does not give every second tick.");

endmodule

/* rtl/power_save_clock_control.sv */
// Idle, sleep and slow-CPU clock control with the PLL feedback divisor register.
`timescale 1ns/1ps

module power_save_clock_control (
  // Clock and reset
  input  wire logic                                     CLK_I,
  input  wire logic                                     RST_I,
  input  wire logic                                     POR_I,
  // Register port
  input  wire logic [clock_ctrl_pkg::ADDR_W-1:0]        ADDR_I,
  input  wire logic [clock_ctrl_pkg::DATA_W-1:0]        WR_DATA_I,
  input  wire logic                                     WR_I,
  input  wire logic                                     RD_I,
  output logic      [clock_ctrl_pkg::DATA_W-1:0]        RD_DATA_O,
  // Core and wake sources
  input  wire clock_ctrl_pkg::psave_req_t               PSAVE_I,
  input  wire logic                                     IRQ_I,
  input  wire logic                                     WDT_TIMEOUT_I,
  input  wire logic                                     WDT_EN_I,
  input  wire logic                                     CLK_MON_EN_I,
  // Clock controls
  output logic                                          CPU_CLK_EN_O,
  output logic                                          SYS_CLK_RUN_O,
  output logic      [clock_ctrl_pkg::NUM_PERIPH-1:0]    PERIPH_CLK_EN_O,
  output logic                                          RC_OSC_RUN_O,
  output logic      [clock_ctrl_pkg::MULT_W-1:0]        PLL_MULT_O,
  // Events
  output logic                                          WDT_CLEAR_O,
  output logic                                          RESUME_O,
  output logic                                          RESUME_IRQ_O
);

  clock_ctrl_pkg::pwr_state_t                   state_r;
  clock_ctrl_pkg::pwr_state_t                   state_nxt;
  clock_ctrl_pkg::divreg_t                      divreg_r;
  logic [clock_ctrl_pkg::FBDIV_W-1:0]           pll_div_r;
  logic [clock_ctrl_pkg::NUM_PERIPH-1:0]        moddis_r;
  logic [clock_ctrl_pkg::WAKE_CNT_W-1:0]        wake_cnt_r;
  logic                                         sleep_req_r;
  logic                                         by_irq_r;
  logic                                         by_wdt_r;
  logic                                         cpu_en_r;
  logic                                         sys_run_r;
  logic [clock_ctrl_pkg::NUM_PERIPH-1:0]        periph_en_r;
  logic                                         rc_osc_r;
  logic [clock_ctrl_pkg::MULT_W-1:0]            mult_r;
  logic                                         wdt_clr_r;
  logic                                         resume_r;
  logic                                         resume_irq_r;
  logic [clock_ctrl_pkg::DATA_W-1:0]            rdata_r;
  logic [clock_ctrl_pkg::DATA_W-1:0]            rd_mux;
  logic [clock_ctrl_pkg::DATA_W-1:0]            status;
  logic                                         wake_evt;
  logic                                         wr_divreg;
  logic                                         cpu_tick;
  logic                                         low_power;

  assign wake_evt  = IRQ_I || WDT_TIMEOUT_I;
  assign wr_divreg = WR_I && (ADDR_I == clock_ctrl_pkg::ADDR_DIVREG);
  assign low_power = (state_r == clock_ctrl_pkg::ST_IDLE) || (state_r == clock_ctrl_pkg::ST_SLEEP);

  // Power-save sequencing.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      clock_ctrl_pkg::ST_RUN: begin
        if (PSAVE_I.valid) begin
          state_nxt = clock_ctrl_pkg::ST_ENTER;
        end
      end
      clock_ctrl_pkg::ST_ENTER: begin
        // A pending interrupt is not looked at here; entry always completes first.
        state_nxt = sleep_req_r ? clock_ctrl_pkg::ST_SLEEP : clock_ctrl_pkg::ST_IDLE;
      end
      clock_ctrl_pkg::ST_IDLE, clock_ctrl_pkg::ST_SLEEP: begin
        if (wake_evt) begin
          state_nxt = clock_ctrl_pkg::ST_WAKE;
        end
      end
      clock_ctrl_pkg::ST_WAKE: begin
        if (wake_cnt_r == clock_ctrl_pkg::WAKE_LAST) begin
          state_nxt = clock_ctrl_pkg::ST_RUN;
        end
      end
      default: begin
        state_nxt = clock_ctrl_pkg::ST_RUN;
      end
    endcase
  end

  // A device reset on RST_I also ends idle or sleep, since it returns the state to run; POR_I alone does not.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      state_r <= clock_ctrl_pkg::ST_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      sleep_req_r <= 1'b0;
    end else if (state_r == clock_ctrl_pkg::ST_RUN && PSAVE_I.valid) begin
      sleep_req_r <= PSAVE_I.sleep;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I || state_r != clock_ctrl_pkg::ST_WAKE) begin
      wake_cnt_r <= 2'h0;
    end else begin
      wake_cnt_r <= wake_cnt_r + 2'h1;
    end
  end

  // Wake cause stays visible until the next power-save entry.
  always_ff @(posedge CLK_I) begin
    if (RST_I || state_r == clock_ctrl_pkg::ST_ENTER) begin
      by_irq_r <= 1'b0;
      by_wdt_r <= 1'b0;
    end else if (low_power && wake_evt) begin
      by_irq_r <= IRQ_I;
      by_wdt_r <= WDT_TIMEOUT_I && !IRQ_I;
    end
  end

  // Clock divisor register; an interrupt may drop the slow-CPU bit when asked to.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      divreg_r <= clock_ctrl_pkg::DIVREG_RST;
    end else if (wr_divreg) begin
      divreg_r                         <= WR_DATA_I;
      divreg_r.rsvd                    <= clock_ctrl_pkg::DIVREG_RST.rsvd;
    end else if (IRQ_I && divreg_r.return_on_interrupt_bit) begin
      divreg_r.slow_cpu_enable_bit <= 1'b0;
    end
  end

  // Only power-on reset restores the feedback divisor; other resets leave it alone.
  always_ff @(posedge CLK_I) begin
    if (POR_I) begin
      pll_div_r <= clock_ctrl_pkg::FBDIV_RST;
    end else if (!RST_I && WR_I && ADDR_I == clock_ctrl_pkg::ADDR_FBDIV) begin
      pll_div_r <= WR_DATA_I[clock_ctrl_pkg::FBDIV_W-1:0];
    end
  end

  always_ff @(posedge CLK_I) begin
    if (POR_I) begin
      mult_r <= 10'(clock_ctrl_pkg::FBDIV_RST) + clock_ctrl_pkg::PLL_MULT_OFS;
    end else begin
      mult_r <= 10'(pll_div_r) + clock_ctrl_pkg::PLL_MULT_OFS;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      moddis_r <= clock_ctrl_pkg::MODDIS_RST;
    end else if (WR_I && ADDR_I == clock_ctrl_pkg::ADDR_MODDIS) begin
      moddis_r <= WR_DATA_I[clock_ctrl_pkg::NUM_PERIPH-1:0];
    end
  end

  // Slow-CPU divider; the peripherals never see it.
  doze_divider u_div (
    .clk_i   (CLK_I),
    .rst_i   (RST_I),
    .run_i   (state_r == clock_ctrl_pkg::ST_RUN),
    .doze_i  (divreg_r.slow_cpu_enable_bit),
    .ratio_i (divreg_r.ratio),
    .tick_o  (cpu_tick)
  );

  // The CPU stops in the cycle after the power-save instruction.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      cpu_en_r <= 1'b0;
    end else begin
      cpu_en_r <= (state_r == clock_ctrl_pkg::ST_RUN) && !PSAVE_I.valid && cpu_tick;
    end
  end

  // Only sleep stops the system clock; idle and slow-CPU mode keep it.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      sys_run_r <= 1'b1;
    end else begin
      sys_run_r <= (state_nxt != clock_ctrl_pkg::ST_SLEEP);
    end
  end

  // A module disable bit gates its peripheral one cycle after the write.
  genvar p;
  generate
    for (p = 0; p < clock_ctrl_pkg::NUM_PERIPH; p++) begin : g_periph
      always_ff @(posedge CLK_I) begin
        if (RST_I) begin
          periph_en_r[p] <= 1'b1;
        end else begin
          periph_en_r[p] <= !moddis_r[p] && (state_r != clock_ctrl_pkg::ST_SLEEP);
        end
      end
    end
  endgenerate

  // The RC oscillator is kept while anything that depends on it is on.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      rc_osc_r <= 1'b0;
    end else begin
      rc_osc_r <= WDT_EN_I || CLK_MON_EN_I;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      wdt_clr_r <= 1'b0;
    end else begin
      wdt_clr_r <= (state_r == clock_ctrl_pkg::ST_ENTER) && !sleep_req_r;
    end
  end

  // The core resumes at the next instruction, or at the handler when an interrupt woke it.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      resume_r     <= 1'b0;
      resume_irq_r <= 1'b0;
    end else begin
      resume_r     <= (state_r == clock_ctrl_pkg::ST_WAKE) && (state_nxt == clock_ctrl_pkg::ST_RUN);
      resume_irq_r <= (state_r == clock_ctrl_pkg::ST_WAKE) && (state_nxt == clock_ctrl_pkg::ST_RUN)
                      && by_irq_r;
    end
  end

  always_comb begin
    status                                    = 16'h0000;
    status[clock_ctrl_pkg::ST_BIT_IDLE]       = (state_r == clock_ctrl_pkg::ST_IDLE);
    status[clock_ctrl_pkg::ST_BIT_SLEEP]      = (state_r == clock_ctrl_pkg::ST_SLEEP);
    status[clock_ctrl_pkg::ST_BIT_DOZE]       = divreg_r.slow_cpu_enable_bit;
    status[clock_ctrl_pkg::ST_BIT_WAKE]       = (state_r == clock_ctrl_pkg::ST_WAKE);
    status[clock_ctrl_pkg::ST_BIT_BYIRQ]      = by_irq_r;
    status[clock_ctrl_pkg::ST_BIT_BYWDT]      = by_wdt_r;
  end

  // Unmapped offsets read as zero; reserved bits read as zero.
  always_comb begin
    rd_mux = 16'h0000;
    case (ADDR_I)
      clock_ctrl_pkg::ADDR_DIVREG: rd_mux = divreg_r;
      clock_ctrl_pkg::ADDR_FBDIV:  rd_mux = 16'(pll_div_r);
      clock_ctrl_pkg::ADDR_MODDIS: rd_mux = 16'(moddis_r);
      clock_ctrl_pkg::ADDR_STATUS: rd_mux = status;
      default:                     rd_mux = 16'h0000;
    endcase
  end

  // Read data stands for exactly one cycle after the strobe.
  always_ff @(posedge CLK_I) begin
    if (RST_I || !RD_I) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= rd_mux;
    end
  end

  assign RD_DATA_O       = rdata_r;
  assign CPU_CLK_EN_O    = cpu_en_r;
  assign SYS_CLK_RUN_O   = sys_run_r;
  assign PERIPH_CLK_EN_O = periph_en_r;
  assign RC_OSC_RUN_O    = rc_osc_r;
  assign PLL_MULT_O      = mult_r;
  assign WDT_CLEAR_O     = wdt_clr_r;
  assign RESUME_O        = resume_r;
  assign RESUME_IRQ_O    = resume_irq_r;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  cpu_stop_a: assert property (state_r == clock_ctrl_pkg::ST_RUN && PSAVE_I.valid
      |=> !CPU_CLK_EN_O ##1 !CPU_CLK_EN_O ##1 !CPU_CLK_EN_O)
    else $error("CPU clock not stopped after power-save entry.");

  wdt_clear_a: assert property (state_r == clock_ctrl_pkg::ST_RUN && PSAVE_I.valid
      && !PSAVE_I.sleep |=> ##1 WDT_CLEAR_O ##1 !WDT_CLEAR_O)
    else $error("Watchdog clear pulse missing on idle entry.");

  idle_clock_a: assert property (state_r == clock_ctrl_pkg::ST_IDLE && !moddis_r[0]
      |=> SYS_CLK_RUN_O && PERIPH_CLK_EN_O[0])
    else $error("Idle stopped the system or peripheral clock.");

  idle_osc_a: assert property (state_r == clock_ctrl_pkg::ST_IDLE && $stable(WDT_EN_I)
      && WDT_EN_I |=> RC_OSC_RUN_O)
    else $error("RC oscillator stopped in idle with watchdog on.");

  wake_event_a: assert property (low_power && wake_evt
      |=> state_r == clock_ctrl_pkg::ST_WAKE)
    else $error("Idle or sleep did not leave on a wake event.");

  // The event cycle, two wake cycles and the first run cycle pass before the CPU ticks.
  resume_time_a: assert property (low_power && wake_evt && !PSAVE_I.valid
      |-> !CPU_CLK_EN_O [*4] ##1 CPU_CLK_EN_O)
    else $error("CPU did not resume within two to four cycles.");

  irq_defer_a: assert property (state_r == clock_ctrl_pkg::ST_ENTER
      |=> low_power)
    else $error("Power-save entry did not complete before waking.");

  // A tick right after the divisor word changes may still be a full-speed one.
  doze_full_a: assert property (divreg_r.slow_cpu_enable_bit && divreg_r.ratio != 3'h0
      && $stable(divreg_r)
      && state_r == clock_ctrl_pkg::ST_RUN && !PSAVE_I.valid && CPU_CLK_EN_O
      |=> SYS_CLK_RUN_O && !CPU_CLK_EN_O)
    else $error("Slow-CPU mode slowed the system clock or not the CPU.");

  roi_exit_a: assert property (divreg_r.slow_cpu_enable_bit
      && divreg_r.return_on_interrupt_bit
      && IRQ_I && !wr_divreg |=> !divreg_r.slow_cpu_enable_bit)
    else $error("Interrupt did not restore full CPU speed.");

  roi_hold_a: assert property (divreg_r.slow_cpu_enable_bit
      && !divreg_r.return_on_interrupt_bit
      && IRQ_I && !wr_divreg |=> divreg_r.slow_cpu_enable_bit)
    else $error("Interrupt left slow-CPU mode without return enable.");

  pll_mult_a: assert property (!POR_I && $stable(pll_div_r)
      |=> PLL_MULT_O == 10'($past(pll_div_r)) + clock_ctrl_pkg::PLL_MULT_OFS)
    else $error("PLL multiplier is not the field plus two.");

  pll_keep_a: assert property (@(posedge CLK_I) disable iff (POR_I)
      RST_I |=> $stable(pll_div_r))
    else $error("Feedback divisor changed on a non power-on reset.");

  moddis_delay_a: assert property ($rose(moddis_r[0]) && state_r != clock_ctrl_pkg::ST_SLEEP
      |-> PERIPH_CLK_EN_O[0] ##1 !PERIPH_CLK_EN_O[0])
    else $error("Module disable did not act one cycle later.");

  idle_irq_c:  cover property (state_r == clock_ctrl_pkg::ST_IDLE && IRQ_I ##3 RESUME_IRQ_O);
  sleep_wdt_c: cover property (state_r == clock_ctrl_pkg::ST_SLEEP && WDT_TIMEOUT_I && !IRQ_I);
  enter_irq_c: cover property (state_r == clock_ctrl_pkg::ST_ENTER && IRQ_I);
  doze_max_c:  cover property (divreg_r.slow_cpu_enable_bit && divreg_r.ratio == 3'h7
      && CPU_CLK_EN_O);

endmodule

/* verif/tb.sv */
// Self-checking testbench of the power-save and clock control block.
`timescale 1ns/1ps

module tb;
  logic                        clk;
  logic                        rst;
  logic                        por;
  logic [3:0]                  addr;
  logic [15:0]                 wdata;
  logic                        wr;
  logic                        rd;
  logic [15:0]                 rdata;
  clock_ctrl_pkg::psave_req_t  psave_req;
  logic                        irq;
  logic                        wdt_to;
  logic                        wdt_en;
  logic                        mon_en;
  logic                        cpu_en;
  logic                        sys_run;
  logic [7:0]                  periph_en;
  logic                        rc_run;
  logic [9:0]                  pll_mult;
  logic                        wdt_clr;
  logic                        resume;
  logic                        resume_irq;
  int                          n_errors;
  int                          check_count;
  int                          seed;
  int                          divreg_m;
  int                          status_m;
  int                          pll_m;
  int                          moddis_m;
  int                          cnt;
  int                          bad;
  logic [15:0]                 v;

  power_save_clock_control dut (.CLK_I(clk), .RST_I(rst), .POR_I(por), .ADDR_I(addr),
    .WR_DATA_I(wdata), .WR_I(wr), .RD_I(rd), .RD_DATA_O(rdata), .PSAVE_I(psave_req),
    .IRQ_I(irq), .WDT_TIMEOUT_I(wdt_to), .WDT_EN_I(wdt_en), .CLK_MON_EN_I(mon_en),
    .CPU_CLK_EN_O(cpu_en), .SYS_CLK_RUN_O(sys_run), .PERIPH_CLK_EN_O(periph_en),
    .RC_OSC_RUN_O(rc_run), .PLL_MULT_O(pll_mult), .WDT_CLEAR_O(wdt_clr),
    .RESUME_O(resume), .RESUME_IRQ_O(resume_irq));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic end_sim();
    $display("checks %0d, errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp, input string what);
    check_count++;
    if (got != exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask

  // The model keeps only the defined bits, so reserved bits are never written.
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    if (a == 4'h0) divreg_m = int'(d) & 32'hf800;
    if (a == 4'h1) pll_m = int'(d) & 32'h01ff;
    if (a == 4'h2) moddis_m = int'(d) & 32'h00ff;
  endtask

  task automatic rd_chk(input logic [3:0] a);
    logic [15:0] exp;
    exp = 16'h0000;
    if (a == 4'h0) exp = divreg_m[15:0];
    if (a == 4'h3) exp = status_m[15:0];
    if (a == 4'h1) exp = pll_m[15:0];
    if (a == 4'h2) exp = moddis_m[15:0];
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    chk_word(rdata, exp, "read data");
  endtask

  // Count CPU ticks over a window that is a whole number of every doze period.
  task automatic count_ticks(input int cycles);
    cnt = 0;
    bad = 0;
    repeat (cycles) begin
      @(posedge clk);
      #1;
      cnt += int'(cpu_en === 1'b1);
      bad += int'(sys_run !== 1'b1 || periph_en !== ~moddis_m[7:0]);
    end
    chk_cnt(bad, 0, "peripheral clock slowed");
  endtask

  task automatic psave(input logic slp, input logic with_irq);
    @(posedge clk);
    psave_req <= '{valid: 1'b1, sleep: slp};
    irq    <= with_irq;
    @(posedge clk);
    psave_req <= '0;
    #1;
    chk_word({15'h0, cpu_en}, 16'h0000, "cpu tick on entry");
    @(posedge clk);
    #1;
    chk_word({15'h0, wdt_clr}, {15'h0, ~slp}, "watchdog clear");
  endtask

  task automatic hold_check(input int cycles, input logic slp);
    bad = 0;
    repeat (cycles) begin
      @(posedge clk);
      #1;
      bad += int'(cpu_en !== 1'b0 || sys_run !== ~slp);
      bad += int'(!slp && periph_en !== ~moddis_m[7:0]);
    end
    chk_cnt(bad, 0, "halted state");
  endtask

  task automatic wake_wait(input int exp_n, input logic exp_irq);
    int n;
    n = 0;
    bad = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
      bad += int'(resume !== 1'b1 && cpu_en !== 1'b0);
    end while (resume !== 1'b1 && n < 8);
    if (n >= 8) begin
      n_errors++;
      $display("mismatch at %0t: no wake-up", $time);
      end_sim();
    end
    chk_cnt(bad, 0, "cpu ran while waking");
    chk_cnt(n, exp_n, "wake latency");
    chk_word({15'h0, resume_irq}, {15'h0, exp_irq}, "handler entry");
    // The CPU tick returns in the cycle after the resume pulse.
    @(posedge clk);
    #1;
    chk_word({15'h0, cpu_en}, 16'h0001, "cpu clock back");
    chk_word({15'h0, resume}, 16'h0000, "resume pulse length");
  endtask

  initial begin
    #(20 * 60000);
    n_errors++;
    $display("mismatch at %0t: run timed out", $time);
    end_sim();
  end

  initial begin
    {rst, por, wr, rd, irq, wdt_to, wdt_en, mon_en} = 8'hc0;
    addr = 4'h0;
    wdata = 16'h0000;
    psave_req = '0;
    n_errors = 0;
    check_count = 0;
    seed = 59;
    divreg_m = 0;
    status_m = 0;
    pll_m = 32'h030;
    moddis_m = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    por <= 1'b0;
    @(posedge clk);
    #1;
    chk_word({15'h0, cpu_en}, 16'h0001, "cpu tick after reset");
    chk_word({6'h0, pll_mult}, 16'h0032, "default multiplier");
    rd_chk(4'h0);
    rd_chk(4'h1);
    rd_chk(4'h2);
    // Writes to the status word and an unmapped word change nothing.
    reg_wr(4'h3, 16'hffff);
    reg_wr(4'hc, 16'hffff);
    rd_chk(4'hc);
    rd_chk(4'h0);
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 16'h0000 : (i == 1) ? 16'h01ff : 16'($random(seed)) & 16'h01ff;
      reg_wr(4'h1, v);
      rd_chk(4'h1);
      chk_word({6'h0, pll_mult}, v + 16'h0002, "multiplier");
      v = 16'($random(seed)) & 16'h00ff;
      reg_wr(4'h2, v);
      @(posedge clk);
      #1;
      chk_word({8'h0, periph_en}, {8'h0, ~v[7:0]}, "module disable");
    end
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    divreg_m = 0;
    moddis_m = 0;
    rd_chk(4'h1);
    chk_word({6'h0, pll_mult}, 16'(pll_m + 2), "multiplier kept");
    for (int n = 0; n < 8; n++) begin
      reg_wr(4'h0, 16'h0800 | 16'(n << 12));
      count_ticks(256);
      chk_cnt(cnt, 256 >> n, "doze ticks");
    end
    reg_wr(4'h0, 16'h7000);
    count_ticks(256);
    chk_cnt(cnt, 256, "doze off ticks");
    reg_wr(4'h0, 16'ha800);
    irq <= 1'b1;
    divreg_m = divreg_m & 32'hf7ff;
    count_ticks(4);
    count_ticks(16);
    chk_cnt(cnt, 16, "full speed on interrupt");
    rd_chk(4'h0);
    reg_wr(4'h0, 16'h2800);
    count_ticks(16);
    chk_cnt(cnt, 4, "doze kept on interrupt");
    rd_chk(4'h0);
    irq <= 1'b0;
    reg_wr(4'h0, 16'h0000);
    psave(1'b0, 1'b1);
    wake_wait(3, 1'b1);
    irq <= 1'b0;
    psave(1'b0, 1'b0);
    for (int c = 0; c < 4; c++) begin
      wdt_en  <= c[0];
      mon_en  <= c[1];
      hold_check(3, 1'b0);
      chk_word({15'h0, rc_run}, {15'h0, c[0] | c[1]}, "rc oscillator");
    end
    @(posedge clk);
    wdt_to <= 1'b1;
    @(posedge clk);
    wdt_to <= 1'b0;
    wake_wait(2, 1'b0);
    // Woken by the watchdog alone, in run, with slow-CPU mode off.
    status_m = 32'h0020;
    rd_chk(4'h3);
    psave(1'b1, 1'b0);
    hold_check(4, 1'b1);
    @(posedge clk);
    irq <= 1'b1;
    wake_wait(3, 1'b1);
    irq <= 1'b0;
    psave(1'b0, 1'b0);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk_word({15'h0, cpu_en}, 16'h0001, "reset wakes idle");
    rd_chk(4'h1);
    end_sim();
  end
endmodule
